/* logic/dual_adc_serial_readout.v */
// Serial readout and conversion sequencing of a dual 12-bit converter.
// Assumes chip select and serial clock come from a host outside the clock
// domain; both are sampled by ref_clk_i, which must run well above SCLK.
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_regs.vh"

module dual_adc_serial_readout
(
   // Clock and reset
   input  wire                  ref_clk_i,
   input  wire                  rst_n_i,
   // Host serial link
   input  wire                  cs_n_i,
   input  wire                  sclk_i,
   output reg                   dout_a_o,
   output reg                   dout_a_oe_o,
   output reg                   dout_b_o,
   output reg                   dout_b_oe_o,
   // Configuration pins
   input  wire                  range_i,
   input  wire                  input_config_select_i,
   input  wire [2:0]            channel_pair_select_i,
   // Analog front end
   input  wire                  cmp_a_i,
   input  wire                  cmp_b_i,
   output wire [`SAR_BITS-1:0]  trial_a_o,
   output wire [`SAR_BITS-1:0]  trial_b_o,
   output reg                   track_o,
   output reg                   range_double_o,
   output reg                   input_config_o,
   output reg  [2:0]            channel_pair_o
);

   localparam ST_IDLE  = 1'b0;
   localparam ST_FRAME = 1'b1;

   reg                  state;
   reg                  next_state;
   reg [`CNT_W-1:0]     cnt;
   reg [`CNT_W-1:0]     next_cnt;

   // Two-flop synchronisers; only the second stage is read by logic
   reg [1:0]            cs_s;
   reg [1:0]            sclk_s;
   reg                  sclk_d;
   reg                  cs_d;
   reg [1:0]            range_s;
   reg [1:0]            cfg_s;
   reg [2:0]            sel_s1;
   reg [2:0]            sel_s2;
   reg [1:0]            cmp_s1;
   reg [1:0]            cmp_s2;

   wire                 cs_fall;
   wire                 sclk_fall;
   wire                 sar_step;
   wire [1:0]           sar_done;
   wire [2*`SAR_BITS-1:0] code_bus;
   wire [1:0]           cmp_raw;

   assign cmp_raw   = {cmp_b_i, cmp_a_i};
   assign cs_fall   = cs_d & ~cs_s[1];
   assign sclk_fall = sclk_d & ~sclk_s[1];
   assign sar_step  = sclk_fall & (state == ST_FRAME);
   assign trial_a_o = code_bus[`SAR_BITS-1:0];
   assign trial_b_o = code_bus[2*`SAR_BITS-1:`SAR_BITS];

   // Bit shown in a given frame slot: lead zeros, result, then chained result
   function slot_bit;
      input [`CNT_W-1:0]    c;
      input [`SAR_BITS-1:0] own;
      input [`SAR_BITS-1:0] other;
      input                 dbl;
      reg   [3:0]           pos;
      reg   [3:0]           idx;
      reg   [`SAR_BITS-1:0] src;
      begin
         pos      = c[`SLOT_POS_MSB:0];
         src      = c[`SLOT_CHAIN_BIT] ? other : own;
         idx      = `DATA_LAST - pos;
         slot_bit = 1'b0;
         if (!c[`SLOT_OVER_BIT] && (pos >= `LEAD_ZEROS) && (pos <= `DATA_LAST))
         begin
            // Inverting the MSB turns offset binary into twos complement
            slot_bit = src[idx] ^ (dbl & (idx == `RESULT_MSB));
         end
      end
   endfunction

   // Pin synchronisers and edge history
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cs_s    <= `SYNC2_RST;
         cs_d    <= `SYNC1_RST;
         sclk_s  <= `SYNC2_RST;
         sclk_d  <= `SYNC1_RST;
         range_s <= `SYNC_LOW_RST;
         cfg_s   <= `SYNC_LOW_RST;
         sel_s1  <= `SEL_RST;
         sel_s2  <= `SEL_RST;
         cmp_s1  <= `SYNC_LOW_RST;
         cmp_s2  <= `SYNC_LOW_RST;
      end
      else
      begin
         cs_s    <= {cs_s[0], cs_n_i};
         cs_d    <= cs_s[1];
         sclk_s  <= {sclk_s[0], sclk_i};
         sclk_d  <= sclk_s[1];
         range_s <= {range_s[0], range_i};
         cfg_s   <= {cfg_s[0], input_config_select_i};
         sel_s1  <= channel_pair_select_i;
         sel_s2  <= sel_s1;
         cmp_s1  <= cmp_raw;
         cmp_s2  <= cmp_s1;
      end
   end

   // One converter per channel, both started by the same chip select fall
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_conv
         sar_channel u_sar
         (
            .clk_i   (ref_clk_i),
            .rst_n_i (rst_n_i),
            .start_i (cs_fall),
            .step_i  (sar_step),
            .cmp_i   (cmp_s2[g]),
            .code_o  (code_bus[g*`SAR_BITS +: `SAR_BITS]),
            .done_o  (sar_done[g])
         );
      end
   endgenerate

   // Frame state and slot count; counter stops after the chained frame
   always @*
   begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_IDLE:
         begin
            if (cs_fall)
            begin
               next_state = ST_FRAME;
               next_cnt   = `CNT_ZERO;
            end
         end
         ST_FRAME:
         begin
            if (cs_s[1])
               next_state = ST_IDLE;      // Early chip select rise ends the frame
            else if (sclk_fall && (cnt != `CNT_CHAIN_END))
               next_cnt = cnt + `CNT_ONE;
         end
         default:
         begin
            next_state = ST_IDLE;
            next_cnt   = `CNT_ZERO;
         end
      endcase
   end

   // Outputs move at frame start or on a falling serial clock edge, and clear when chip select rises
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state       <= ST_IDLE;
         cnt         <= `CNT_ZERO;
         dout_a_o    <= 1'b0;
         dout_b_o    <= 1'b0;
         dout_a_oe_o <= 1'b0;
         dout_b_oe_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
         if (next_state == ST_IDLE)
         begin
            dout_a_oe_o <= 1'b0;
            dout_b_oe_o <= 1'b0;
            dout_a_o    <= 1'b0;
            dout_b_o    <= 1'b0;
         end
         else if (cs_fall || sclk_fall)
         begin
            dout_a_oe_o <= 1'b1;
            dout_b_oe_o <= 1'b1;
            // Both pins shift together, each leading with its own result
            dout_a_o <= slot_bit(next_cnt, trial_a_o, trial_b_o, range_double_o);
            dout_b_o <= slot_bit(next_cnt, trial_b_o, trial_a_o, range_double_o);
         end
      end
   end

   // Range, input config and channel pair are caught at chip select fall
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         range_double_o <= 1'b0;
         input_config_o <= 1'b0;
         channel_pair_o <= `SEL_RST;
      end
      else if (cs_fall)
      begin
         range_double_o <= range_s[1];
         input_config_o <= cfg_s[1];
         channel_pair_o <= sel_s2;
      end
   end

   // Hold from sampling until both converters finish, then track again
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         track_o <= 1'b1;
      else if (cs_fall)
         track_o <= 1'b0;
      else
         track_o <= &sar_done;
   end

endmodule

`default_nettype wire

/* logic/adc_readout_regs.vh */
// Constants for the dual converter serial readout: frame slots, code
// widths and reset values. Definitions only; included by bare name.
`ifndef ADC_READOUT_REGS_VH
`define ADC_READOUT_REGS_VH

// Result code layout
`define SAR_BITS        12
`define SAR_MSB_MASK    12'h800
`define SAR_ZERO        12'h000
`define RESULT_MSB      4'hB

// Frame slot counter, one count per serial clock falling edge
`define CNT_W           6
`define CNT_ZERO        6'h00
`define CNT_ONE         6'h01
`define CNT_CHAIN_END   6'h20
`define LEAD_ZEROS      4'h2
`define DATA_LAST       4'hD
`define SLOT_POS_MSB    3
`define SLOT_CHAIN_BIT  4
`define SLOT_OVER_BIT   5

// Synchroniser and control reset values
`define SYNC2_RST       2'h3
`define SYNC1_RST       1'h1
`define SEL_RST         3'h0
`define SYNC_LOW_RST    2'h0

`endif

/* logic/sar_channel.v */
// One successive approximation register for a single converter.
// Assumes a synchronised comparator bit and one-cycle start and step pulses.
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_regs.vh"

module sar_channel
(
   // Clock and reset
   input  wire                  clk_i,
   input  wire                  rst_n_i,
   // Control
   input  wire                  start_i,
   input  wire                  step_i,
   input  wire                  cmp_i,
   // Trial code to the capacitive DAC, decided bits above the mask
   output reg  [`SAR_BITS-1:0]  code_o,
   output wire                  done_o
);

   reg [`SAR_BITS-1:0] mask;

   // Conversion is over once the trial bit has walked past the LSB
   assign done_o = (mask == `SAR_ZERO);

   // Start sets the MSB trial; each step keeps or drops the trial bit
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mask   <= `SAR_ZERO;
         code_o <= `SAR_ZERO;
      end
      else if (start_i)
      begin
         mask   <= `SAR_MSB_MASK;
         code_o <= `SAR_MSB_MASK;
      end
      else if (step_i && !done_o)
      begin
         // Comparator high means input at or above the trial level
         code_o <= (cmp_i ? code_o : (code_o & ~mask)) | (mask >> 1);
         mask   <= mask >> 1;
      end
   end

endmodule

`default_nettype wire

/* tb/readout_monitor.sv */
// Checker for the dual converter serial readout, on the top module's ports.
// Assumes the host holds range and channel pair pins steady through a frame.
`timescale 1ns/1ps
`default_nettype none
module readout_monitor
(
   // Clock, reset and link
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   input wire logic        cs_n_i,
   input wire logic        sclk_i,
   // Data outputs and sequencing
   input wire logic        dout_a_o,
   input wire logic        dout_a_oe_o,
   input wire logic        dout_b_oe_o,
   input wire logic        track_o,
   input wire logic [11:0] trial_a_o,
   // Configuration pins and their latches
   input wire logic        range_i,
   input wire logic        range_double_o,
   input wire logic [2:0]  channel_pair_select_i,
   input wire logic [2:0]  channel_pair_o
);
   // Six samples cover the two synchroniser flops plus the edge flop
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_oe_idle_low: assert property (cs_n_i [*6] |-> !dout_a_oe_o)
      else $error("data enable high outside a frame");
   chk_oe_frame_high: assert property (!cs_n_i [*6] |-> dout_a_oe_o)
      else $error("data enable low inside a frame");
   chk_dout_quiet: assert property (!dout_a_oe_o |-> !dout_a_o)
      else $error("data driven while not enabled");
   chk_oe_pair_same: assert property (dout_a_oe_o == dout_b_oe_o)
      else $error("data enables differ");
   chk_bit_on_fall: assert property (
      $changed(dout_a_o) && dout_a_oe_o && $past(dout_a_oe_o) |-> !$past(sclk_i, 3))
      else $error("data bit changed away from a falling serial clock");
   chk_hold_on_start: assert property ($fell(cs_n_i) |-> ##[2:6] !track_o)
      else $error("no hold after chip select fall");
   chk_track_return: assert property ($fell(track_o) |-> ##[100:250] track_o)
      else $error("track-and-hold did not return to tracking");
   chk_range_latch: assert property (
      $fell(cs_n_i) |-> ##6 (range_double_o == range_i
      && channel_pair_o == channel_pair_select_i))
      else $error("range or channel pair not latched at frame start");
   chk_trial_first: assert property ($fell(cs_n_i) |-> ##6 trial_a_o == 12'h800)
      else $error("first trial code wrong before first serial clock");
endmodule
bind dual_adc_serial_readout readout_monitor u_mon (.ref_clk_i, .rst_n_i, .cs_n_i, .sclk_i,
   .dout_a_o, .dout_a_oe_o, .dout_b_oe_o, .track_o, .trial_a_o, .range_i, .range_double_o,
   .channel_pair_select_i, .channel_pair_o);
`default_nettype wire

/* tb/host_model.sv */
// Host model: frames chip select, gives serial clocks, captures both data pins.
// Assumes undriven data pins float; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   // Link to the device
   output logic        cs_n_o,
   output logic        sclk_o,
   input  wire logic   pin_a_i,
   input  wire logic   pin_b_i,
   // Captured bits, latest in the lowest place
   output logic [31:0] cap_a_o,
   output logic [31:0] cap_b_o
);
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
   end
   // Sample just before each fall, the latest moment a bit is sure to stand
   // Start 1 ns past the reference edge so no pin change races the synchronisers
   task frame(input int n);
      #1;
      cap_a_o = 32'h0;
      cap_b_o = 32'h0;
      cs_n_o <= 1'b0;
      repeat (n)
      begin
         #62.5;
         cap_a_o = {cap_a_o[30:0], pin_a_i};
         cap_b_o = {cap_b_o[30:0], pin_b_i};
         sclk_o <= 1'b0;
         #62.5;
         sclk_o <= 1'b1;
      end
      #62.5;
      cs_n_o <= 1'b1;
      #300;
   endtask
endmodule
`default_nettype wire

/* tb/test_dual_adc_serial_readout.sv */
// Testbench for the dual converter serial readout with ideal comparators.
// Assumes the host model frames transfers; pins float when not enabled.
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_serial_readout;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, range_i = 1'b0, input_config_select_i = 1'b0;
   logic cmp_a_i = 1'b0, cmp_b_i = 1'b0;
   logic [2:0]  channel_pair_select_i = 3'h0;
   logic [11:0] vin_a = 12'h000, vin_b = 12'h000;
   wire  logic  cs_n_i, sclk_i, dout_a_o, dout_a_oe_o, dout_b_o, dout_b_oe_o, track_o;
   wire  logic  range_double_o, input_config_o, pin_a, pin_b;
   wire  logic [2:0]  channel_pair_o;
   wire  logic [11:0] trial_a_o, trial_b_o;
   wire  logic [31:0] cap_a, cap_b;
   int   failures = 0, n_checks = 0;
   // Pins float when not enabled, so a stale bit cannot pass
   assign pin_a = dout_a_oe_o ? dout_a_o : 1'bz;
   assign pin_b = dout_b_oe_o ? dout_b_o : 1'bz;
   dual_adc_serial_readout DUT (.ref_clk_i, .rst_n_i, .cs_n_i, .sclk_i, .dout_a_o,
      .dout_a_oe_o, .dout_b_o, .dout_b_oe_o, .range_i, .input_config_select_i,
      .channel_pair_select_i, .cmp_a_i, .cmp_b_i, .trial_a_o, .trial_b_o, .track_o,
      .range_double_o, .input_config_o, .channel_pair_o);
   host_model u_host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .pin_a_i(pin_a), .pin_b_i(pin_b),
      .cap_a_o(cap_a), .cap_b_o(cap_b));
   initial
   begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Ideal comparators: a trial bit is kept when the input is not below it
   always @(posedge ref_clk_i)
   begin
      cmp_a_i <= (vin_a >= trial_a_o);
      cmp_b_i <= (vin_b >= trial_b_o);
   end
   task check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   // Leading zeros, own code, four zeros, other code, two zeros; first n kept
   function automatic logic [31:0] word(input logic [11:0] own, other, input int n);
      word = {2'b00, own, 4'h0, other, 2'b00} >> (32 - n);
   endfunction
   task setup(input logic r, input logic [2:0] p, input logic [11:0] a, b);
      @(posedge ref_clk_i);
      range_i <= r;
      input_config_select_i <= p[0];
      channel_pair_select_i <= p;
      vin_a <= a;
      vin_b <= b;
      repeat (5) @(posedge ref_clk_i);
   endtask
   task idle_checks;
      check({31'h0, pin_a}, {31'h0, 1'bz});
      check({31'h0, pin_b}, {31'h0, 1'bz});
      check({31'h0, track_o}, 32'h1);
   endtask
   // Chained frame: each pin gives its own result, then the other one
   task run_chain;
      setup(1'b0, 3'h5, 12'hA5C, 12'h3F1);
      u_host.frame(32);
      check(cap_a, word(12'hA5C, 12'h3F1, 32));
      check(cap_b, word(12'h3F1, 12'hA5C, 32));
      idle_checks();
   endtask
   // Sixteen clocks with extreme codes: result then two trailing zeros
   task run_trailing;
      setup(1'b0, 3'h2, 12'hFFF, 12'h001);
      u_host.frame(16);
      check(cap_a, word(12'hFFF, 12'h001, 16));
      check(cap_b, word(12'h001, 12'hFFF, 16));
      check({20'h0, trial_a_o}, {20'h0, 12'hFFF});
      check({20'h0, trial_b_o}, {20'h0, 12'h001});
      idle_checks();
   endtask
   // Reset between frames clears codes and latches; the next frame still works
   task run_reset;
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      check({20'h0, trial_a_o}, 32'h0);
      check({29'h0, channel_pair_o}, 32'h0);
      idle_checks();
      rst_n_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      setup(1'b1, 3'h1, 12'h000, 12'hFFF);
      u_host.frame(14);
      check(cap_a, 32'h0800);
      check(cap_b, 32'h07FF);
      idle_checks();
   endtask
   // Doubled range either side of midscale: midscale flips to all zeros, one below to all ones
   task run_twos;
      setup(1'b1, 3'h7, 12'h800, 12'h7FF);
      u_host.frame(14);
      check(cap_a, 32'h0);
      check(cap_b, 32'h0FFF);
      check({31'h0, range_double_o}, 32'h1);
      idle_checks();
   endtask
   // Every channel pair code, each in a plain fourteen-clock frame
   task run_pairs;
      for (int p = 0; p < 8; p++)
      begin
         setup(1'b0, p[2:0], {3{1'b0, p[2:0]}}, ~{3{1'b0, p[2:0]}});
         u_host.frame(14);
         check(cap_a, word({3{1'b0, p[2:0]}}, 12'h0, 14));
         check(cap_b, word(~{3{1'b0, p[2:0]}}, 12'h0, 14));
         check({29'h0, channel_pair_o}, {29'h0, p[2:0]});
         check({31'h0, input_config_o}, {31'h0, p[0]});
      end
   endtask
   task give_verdict;
      $display("Checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      run_chain();
      run_trailing();
      run_twos();
      run_pairs();
      run_reset();
      give_verdict();
   end
   // A hung run counts as a failure
   initial
   begin
      #200000;
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
